// ===== logic/rss_pkg.sv
// Purpose: Shared constants and types for the rotate, subtract and sleep execution datapath.
// Assumes: One core clock; an 8-bit accumulator and a 128-byte file register space.
// Notes: Register port offsets are byte addresses on an 8-bit address.
`default_nettype none

package rss_pkg;

	// ----------------------------------------
	// Widths and register port map
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int FILE_AW = 7;
	localparam int REG_AW = 8;
	localparam logic [7:0] FILE_LAST_OFF = 8'h7F;
	localparam logic [7:0] ACC_OFF = 8'h80;
	localparam logic [7:0] STATUS_OFF = 8'h81;

	// ----------------------------------------
	// Status field positions and reset values
	// ----------------------------------------
	localparam int CARRY_POS = 0;
	localparam int NIBBLE_POS = 1;
	localparam int NULL_POS = 2;
	localparam int POWERDOWN_POS = 3;
	localparam int TIMEOUT_POS = 4;
	localparam int SLEEP_POS = 5;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic CARRY_RESET = 1'b0;
	localparam logic NIBBLE_RESET = 1'b0;
	localparam logic NULL_RESET = 1'b0;
	localparam logic POWERDOWN_RESET = 1'b1;
	localparam logic TIMEOUT_RESET = 1'b1;

	// ----------------------------------------
	// Instruction carrier
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NOP = 3'h0,
		OP_ROTATE_RIGHT_VIA_CARRY = 3'h1,
		OP_SUBTRACT_ACC_FROM_LITERAL = 3'h2,
		OP_SUBTRACT_ACC_FROM_FILE = 3'h3,
		OP_SUBTRACT_ACC_FROM_FILE_WITH_BORROW = 3'h4,
		OP_SLEEP = 3'h5
	} op_t;

	typedef struct packed {
		op_t op;
		logic [FILE_AW-1:0] file_addr;
		logic dest;
		logic [DATA_W-1:0] literal;
	} instr_t;

	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	typedef struct packed {
		logic timeout_status;
		logic powerdown_status;
		logic result_null_flag;
		logic nibble_borrow_bit;
		logic borrow_inverse_bit;
	} status_t;

	typedef enum logic {
		PWR_RUN = 1'b0,
		PWR_SLEEP = 1'b1
	} pwr_state_t;

endpackage

`default_nettype wire

// ===== logic/sub_unit.sv
// Purpose: Eight-bit subtractor producing difference, borrow, nibble borrow and null flags.
// Assumes: Borrow flags are inverted, so 1 means no borrow occurred.
// Notes: Purely combinational; the caller registers the results.
`default_nettype none

module sub_unit #(
	parameter int W = 8
) (
	input wire logic [W-1:0] minuend,
	input wire logic [W-1:0] subtrahend,
	input wire logic borrow_in_inv,
	input wire logic use_borrow,
	output logic [W-1:0] diff,
	output logic borrow_out_inv,
	output logic nibble_out_inv,
	output logic null_out
);

	logic carry_in;
	logic [W:0] full_sum;
	logic [4:0] low_sum;

	// Subtraction as minuend plus inverted subtrahend plus one, less any pending borrow.
	assign carry_in = use_borrow ? borrow_in_inv : 1'b1;
	assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, carry_in};
	assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
	assign diff = full_sum[W-1:0];
	assign borrow_out_inv = full_sum[W];
	assign nibble_out_inv = low_sum[4];
	assign null_out = (full_sum[W-1:0] == '0);

endmodule

`default_nettype wire

// ===== logic/rotate_subtract_sleep_exec.sv
// Purpose: Executes rotate right through borrow, the subtract family and sleep for an 8-bit core.
// Assumes: One instruction per cycle when instr_valid is high and instr_ready is high.
// Notes: Instruction execution wins over a register port write in the same cycle.
`default_nettype none

module rotate_subtract_sleep_exec (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic instr_valid,
	input wire rss_pkg::instr_t instr,
	output logic instr_ready,
	input wire logic wake_req,
	output logic watchdog_clear,
	output logic osc_run,
	input wire logic [rss_pkg::REG_AW-1:0] reg_addr,
	input wire logic [rss_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [rss_pkg::DATA_W-1:0] reg_rdata
);

	// ----------------------------------------
	// Reset release and wake synchroniser
	// ----------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic wake_meta_reg;
	logic wake_sync_reg;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wake_meta_reg <= 1'b0;
			wake_sync_reg <= 1'b0;
		end
		else
		begin
			wake_meta_reg <= wake_req;
			wake_sync_reg <= wake_meta_reg;
		end
	end

	// ----------------------------------------
	// Operand selection and results
	// ----------------------------------------
	logic [rss_pkg::DATA_W-1:0] file_mem [0:(1 << rss_pkg::FILE_AW)-1];
	logic [rss_pkg::DATA_W-1:0] acc_reg;
	rss_pkg::status_t status_reg;
	rss_pkg::pwr_state_t pwr_reg;
	logic fire;
	logic is_sub;
	logic to_file_op;
	logic [rss_pkg::DATA_W-1:0] file_val;
	logic [rss_pkg::DATA_W-1:0] minuend;
	logic [rss_pkg::DATA_W-1:0] rot_res;
	logic [rss_pkg::DATA_W-1:0] result;
	logic [rss_pkg::DATA_W-1:0] diff;
	logic sub_borrow;
	logic sub_nibble;
	logic sub_null;

	assign instr_ready = (pwr_reg == rss_pkg::PWR_RUN);
	assign fire = instr_valid && instr_ready;
	assign is_sub = (instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_LITERAL) ||
		(instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_FILE) ||
		(instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_FILE_WITH_BORROW);
	assign to_file_op = (instr.op == rss_pkg::OP_ROTATE_RIGHT_VIA_CARRY) ||
		(instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_FILE) ||
		(instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_FILE_WITH_BORROW);
	assign file_val = file_mem[instr.file_addr];
	assign minuend = (instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_LITERAL) ? instr.literal : file_val;
	assign rot_res = {status_reg.borrow_inverse_bit, file_val[rss_pkg::DATA_W-1:1]};
	assign result = (instr.op == rss_pkg::OP_ROTATE_RIGHT_VIA_CARRY) ? rot_res : diff;

	sub_unit #(
		.W(rss_pkg::DATA_W)
	) u_sub (
		.minuend(minuend),
		.subtrahend(acc_reg),
		.borrow_in_inv(status_reg.borrow_inverse_bit),
		.use_borrow(instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_FILE_WITH_BORROW),
		.diff(diff),
		.borrow_out_inv(sub_borrow),
		.nibble_out_inv(sub_nibble),
		.null_out(sub_null)
	);

	// ----------------------------------------
	// Accumulator and file registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			acc_reg <= rss_pkg::ACC_RESET;
		else if (fire && (instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_LITERAL))
			acc_reg <= diff;
		else if (fire && to_file_op && (instr.dest == rss_pkg::DEST_ACC))
			acc_reg <= result;
		else if (reg_wr && (reg_addr == rss_pkg::ACC_OFF))
			acc_reg <= reg_wdata;
	end

	// File registers hold data only, so they carry no reset.
	always_ff @(posedge core_clk)
	begin
		if (fire && to_file_op && (instr.dest == rss_pkg::DEST_FILE))
			file_mem[instr.file_addr] <= result;
		else if (reg_wr && (reg_addr <= rss_pkg::FILE_LAST_OFF))
			file_mem[reg_addr[rss_pkg::FILE_AW-1:0]] <= reg_wdata;
	end

	// ----------------------------------------
	// Status bits
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_reg.borrow_inverse_bit <= rss_pkg::CARRY_RESET;
			status_reg.nibble_borrow_bit <= rss_pkg::NIBBLE_RESET;
			status_reg.result_null_flag <= rss_pkg::NULL_RESET;
			status_reg.powerdown_status <= rss_pkg::POWERDOWN_RESET;
			status_reg.timeout_status <= rss_pkg::TIMEOUT_RESET;
		end
		else if (fire && (instr.op == rss_pkg::OP_ROTATE_RIGHT_VIA_CARRY))
			status_reg.borrow_inverse_bit <= file_val[0];
		else if (fire && is_sub)
		begin
			status_reg.borrow_inverse_bit <= sub_borrow;
			status_reg.nibble_borrow_bit <= sub_nibble;
			status_reg.result_null_flag <= sub_null;
		end
		else if (fire && (instr.op == rss_pkg::OP_SLEEP))
		begin
			status_reg.powerdown_status <= 1'b0;
			status_reg.timeout_status <= 1'b1;
		end
		else if (reg_wr && (reg_addr == rss_pkg::STATUS_OFF))
		begin
			status_reg.borrow_inverse_bit <= reg_wdata[rss_pkg::CARRY_POS];
			status_reg.nibble_borrow_bit <= reg_wdata[rss_pkg::NIBBLE_POS];
			status_reg.result_null_flag <= reg_wdata[rss_pkg::NULL_POS];
			status_reg.powerdown_status <= reg_wdata[rss_pkg::POWERDOWN_POS];
			status_reg.timeout_status <= reg_wdata[rss_pkg::TIMEOUT_POS];
		end
	end

	// ----------------------------------------
	// Sleep control
	// ----------------------------------------
	// A wake request already high when sleep executes ends the sleep one cycle later.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pwr_reg <= rss_pkg::PWR_RUN;
		else
		begin
			unique case (pwr_reg)
				rss_pkg::PWR_RUN:
					if (fire && (instr.op == rss_pkg::OP_SLEEP))
						pwr_reg <= rss_pkg::PWR_SLEEP;
				rss_pkg::PWR_SLEEP:
					if (wake_sync_reg)
						pwr_reg <= rss_pkg::PWR_RUN;
			endcase
		end
	end

	// One pulse clears both the watchdog counter and its prescaler outside this block.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			watchdog_clear <= 1'b0;
		else
			watchdog_clear <= fire && (instr.op == rss_pkg::OP_SLEEP);
	end

	assign osc_run = (pwr_reg == rss_pkg::PWR_RUN);

	// ----------------------------------------
	// Register port read
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (reg_rd && (reg_addr <= rss_pkg::FILE_LAST_OFF))
			reg_rdata <= file_mem[reg_addr[rss_pkg::FILE_AW-1:0]];
		else if (reg_rd && (reg_addr == rss_pkg::ACC_OFF))
			reg_rdata <= acc_reg;
		else if (reg_rd && (reg_addr == rss_pkg::STATUS_OFF))
			reg_rdata <= {2'b00, (pwr_reg == rss_pkg::PWR_SLEEP), status_reg};
		else
			reg_rdata <= '0;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	chk_rotate_borrow: assert property (
		fire && instr.op == rss_pkg::OP_ROTATE_RIGHT_VIA_CARRY
		|=> status_reg.borrow_inverse_bit == $past(file_val[0]) && $stable(status_reg.result_null_flag)
			&& $stable(status_reg.nibble_borrow_bit))
		else $error("rotate did not move bit 0 into borrow alone");

	chk_dest_acc_write: assert property (
		fire && to_file_op && instr.dest == rss_pkg::DEST_ACC |=> acc_reg == $past(result))
		else $error("result not written to accumulator");

	chk_literal_sub: assert property (
		fire && instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_LITERAL
		|=> acc_reg == 8'($past(instr.literal) - $past(acc_reg))
			&& status_reg.borrow_inverse_bit == ($past(acc_reg) <= $past(instr.literal)))
		else $error("literal subtract result or borrow wrong");

	chk_nibble_borrow: assert property (
		fire && (instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_LITERAL || instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_FILE)
		|=> status_reg.nibble_borrow_bit == ($past(acc_reg[3:0]) <= $past(minuend[3:0])))
		else $error("nibble borrow wrong");

	chk_file_sub_borrow: assert property (
		fire && instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_FILE
		|=> status_reg.borrow_inverse_bit == ($past(acc_reg) <= $past(file_val)))
		else $error("file subtract borrow wrong");

	chk_borrow_sub_value: assert property (
		fire && instr.op == rss_pkg::OP_SUBTRACT_ACC_FROM_FILE_WITH_BORROW && instr.dest == rss_pkg::DEST_ACC
		|=> acc_reg == 8'($past(file_val) - $past(acc_reg) - {7'h00, !$past(status_reg.borrow_inverse_bit)}))
		else $error("subtract with borrow result wrong");

	chk_sleep_status: assert property (
		fire && instr.op == rss_pkg::OP_SLEEP |=> !status_reg.powerdown_status && status_reg.timeout_status)
		else $error("sleep status bits wrong");

	chk_sleep_watchdog: assert property (
		fire && instr.op == rss_pkg::OP_SLEEP |=> watchdog_clear ##1 !watchdog_clear)
		else $error("watchdog clear not a single pulse after sleep");

	chk_sleep_halts: assert property (
		fire && instr.op == rss_pkg::OP_SLEEP |=> !osc_run && !instr_ready ##1 ($past(wake_sync_reg) || !osc_run))
		else $error("oscillator not halted after sleep");

	chk_null_flag: assert property (
		fire && is_sub |=> status_reg.result_null_flag == ($past(diff) == 8'h00))
		else $error("null flag wrong");

endmodule

`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the rotate, subtract and sleep datapath.
// Assumes: Register port map and status layout as the package declares them.
// Notes: Operands are random from a fixed seed; corner values come first.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic instr_valid = 1'b0;
	rss_pkg::instr_t instr = '0;
	logic wake_req = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic instr_ready, watchdog_clear, osc_run;
	logic [7:0] reg_rdata;
	int err_count = 0;
	int samples_checked = 0;
	integer seed = 32'h0751;
	logic [7:0] acc_m;
	logic [7:0] file_m [128];
	logic [4:0] st_m;
	logic [7:0] rd_v, fv, av;
	logic [6:0] adr;
	rss_pkg::instr_t i1, i2;
	logic [7:0] c_f [4] = '{8'h5A, 8'h00, 8'h10, 8'h80};
	logic [7:0] c_a [4] = '{8'h5A, 8'hFF, 8'h01, 8'h00};

	rotate_subtract_sleep_exec dut (
		.core_clk(core_clk),
		.resetn(resetn),
		.instr_valid(instr_valid),
		.instr(instr),
		.instr_ready(instr_ready),
		.wake_req(wake_req),
		.watchdog_clear(watchdog_clear),
		.osc_run(osc_run),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);

	always #2.5 core_clk = ~core_clk;

	// ----------------------------------------
	// Bus tasks and reference model
	// ----------------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("Checked %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// The read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Result packed as {null, nibble borrow, borrow, difference}.
	function automatic logic [10:0] sub_f(input logic [7:0] a, input logic [7:0] b, input logic cin);
		int d;
		int n;
		d = int'(a) - int'(b) - int'(!cin);
		n = int'(a[3:0]) - int'(b[3:0]) - int'(!cin);
		return {8'(d) == 8'h00, n >= 0, d >= 0, 8'(d)};
	endfunction

	task automatic model(input rss_pkg::instr_t i);
		logic [7:0] f;
		logic [10:0] r;
		f = file_m[i.file_addr];
		case (i.op)
			rss_pkg::OP_ROTATE_RIGHT_VIA_CARRY: r = {st_m[2:1], f[0], st_m[0], f[7:1]};
			rss_pkg::OP_SUBTRACT_ACC_FROM_LITERAL: r = sub_f(i.literal, acc_m, 1'b1);
			rss_pkg::OP_SUBTRACT_ACC_FROM_FILE: r = sub_f(f, acc_m, 1'b1);
			default: r = sub_f(f, acc_m, st_m[0]);
		endcase
		st_m[2:0] = r[10:8];
		if (i.op == rss_pkg::OP_SUBTRACT_ACC_FROM_LITERAL || i.dest == rss_pkg::DEST_ACC)
			acc_m = r[7:0];
		else
			file_m[i.file_addr] = r[7:0];
	endtask

	task automatic issue(input rss_pkg::instr_t i);
		model(i);
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr <= i;
	endtask

	function automatic rss_pkg::instr_t rnd_instr(input logic [6:0] a, input logic [7:0] k);
		rss_pkg::instr_t i;
		i.op = rss_pkg::op_t'(3'h1 + 3'($unsigned($random(seed)) % 4));
		i.file_addr = a;
		i.dest = 1'($random(seed));
		i.literal = k;
		return i;
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		reg_read(8'h81, rd_v);
		check("status after reset", rd_v, 8'h18);
		reg_read(8'h82, rd_v);
		check("unmapped read", rd_v, 8'h00);
		for (int n = 0; n < 40; n++)
		begin
			adr = 7'($random(seed));
			fv = n < 4 ? c_f[n] : 8'($random(seed));
			av = n < 4 ? c_a[n] : 8'($random(seed));
			st_m = {2'b11, 3'($random(seed))};
			reg_write({1'b0, adr}, fv);
			reg_write(8'h80, av);
			reg_write(8'h81, {3'b000, st_m});
			file_m[adr] = fv;
			acc_m = av;
			i1 = rnd_instr(adr, fv);
			i2 = rnd_instr(adr, 8'($random(seed)));
			issue(i1);
			issue(i2);
			@(posedge core_clk);
			instr_valid <= 1'b0;
			reg_read(8'h80, rd_v);
			check("accumulator", rd_v, acc_m);
			reg_read({1'b0, adr}, rd_v);
			check("file register", rd_v, file_m[adr]);
			reg_read(8'h81, rd_v);
			check("status", rd_v, {3'b000, st_m});
		end
		st_m = 5'h07;
		reg_write(8'h81, 8'h07);
		i1 = '0;
		i1.op = rss_pkg::OP_SLEEP;
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr <= i1;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		check("watchdog clear pulse", {7'h00, watchdog_clear}, 8'h01);
		check("oscillator stopped", {6'h00, osc_run, instr_ready}, 8'h00);
		@(posedge core_clk);
		#1;
		check("watchdog clear ends", {7'h00, watchdog_clear}, 8'h00);
		i1.op = rss_pkg::OP_SUBTRACT_ACC_FROM_LITERAL;
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr <= i1;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		wake_req <= 1'b1;
		for (int w = 0; w < 10 && instr_ready !== 1'b1; w++)
			@(posedge core_clk);
		if (instr_ready !== 1'b1)
			err_count++;
		wake_req <= 1'b0;
		reg_read(8'h80, rd_v);
		check("accumulator kept in sleep", rd_v, acc_m);
		reg_read(8'h81, rd_v);
		check("status after sleep", rd_v, 8'h17);
		end_sim();
	end
endmodule

`default_nettype wire
